// ### rtl/umf_pkg.sv
package umf_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] UMF_OFF_DATA = 3'h0;
  localparam logic [2:0] UMF_OFF_CSA = 3'h1;
  localparam logic [2:0] UMF_OFF_CSB = 3'h2;
  localparam logic [2:0] UMF_OFF_CSC = 3'h3;
  localparam logic [2:0] UMF_OFF_IRQ_STAT = 3'h4;
  localparam logic [2:0] UMF_OFF_IRQ_MASK = 3'h5;
  // control_status_a fields
  localparam int UMF_A_RX_DONE = 7;
  localparam int UMF_A_TX_DONE = 6;
  localparam int UMF_A_TX_EMPTY = 5;
  localparam int UMF_A_FE = 4;
  localparam int UMF_A_DOR = 3;
  localparam int UMF_A_FILT = 0;
  // control_status_b fields
  localparam int UMF_B_RXEN = 4;
  localparam int UMF_B_TXEN = 3;
  localparam int UMF_B_SIZE2 = 2;
  localparam int UMF_B_RX9 = 1;
  localparam int UMF_B_TX9 = 0;
  // control_status_c fields
  localparam int UMF_C_STOP2 = 3;
  localparam int UMF_C_SIZE_LO = 1;
  // Interrupt status and mask bits
  localparam int UMF_IRQ_RX = 0;
  localparam int UMF_IRQ_TXC = 1;
  localparam int UMF_IRQ_DROP = 2;
  localparam int UMF_IRQ_W = 3;
  // Reset values and size codes
  localparam logic [2:0] UMF_SIZE_RST = 3'h3;
  localparam logic [2:0] UMF_SIZE_NINE = 3'h7;
  localparam logic [3:0] UMF_NBITS_BASE = 4'h5;
  localparam logic [3:0] UMF_NBITS_NINE = 4'h9;
  localparam logic [3:0] UMF_NBITS_DFLT = 4'h8;
  // Receive entry: {frame_error, nine data bits}
  localparam int UMF_ENTRY_W = 10;
  localparam int UMF_DEPTH = 2;
  localparam int UMF_FE_POS = 9;

  typedef enum logic [1:0] {
    UMF_TX_IDLE = 2'b00,
    UMF_TX_START = 2'b01,
    UMF_TX_DATA = 2'b10,
    UMF_TX_STOP = 2'b11
  } umf_tx_state_t;
endpackage : umf_pkg

// ### rtl/umf_fifo_if.sv
`timescale 1ns/100ps
interface umf_fifo_if;
  import umf_pkg::*;
  logic push;
  logic pop;
  logic flush;
  logic [UMF_ENTRY_W-1:0] push_data;
  logic [UMF_ENTRY_W-1:0] head;
  logic [1:0] count;
  modport fill (output push, output pop, output flush, output push_data, input head, input count);
  modport store (input push, input pop, input flush, input push_data, output head, output count);
endinterface : umf_fifo_if

// ### rtl/umf_rx_fifo.sv
`timescale 1ns/100ps
module umf_rx_fifo (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Storage side
  umf_fifo_if.store fio
);
  import umf_pkg::*;

  logic [UMF_ENTRY_W-1:0] mem_q [UMF_DEPTH];
  logic rd_q;
  logic wr_q;
  logic [1:0] count_q;
  wire do_pop = fio.pop && (count_q != 2'h0);
  wire do_push = fio.push && (count_q != 2'h2);

  ////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < UMF_DEPTH; gi++) begin : g_entry
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          mem_q[gi] <= '0;
        end else if (do_push && (wr_q == 1'(gi))) begin
          mem_q[gi] <= fio.push_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || fio.flush) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      rd_q <= rd_q ^ do_pop;
      wr_q <= wr_q ^ do_push;
      count_q <= count_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // Empty reads show zero, never stale data
  assign fio.head = (count_q == 2'h0) ? '0 : mem_q[rd_q];
  assign fio.count = count_q;
endmodule : umf_rx_fifo

// ### rtl/umf_top.sv
// What this block does
// RQ1 - Filter mode drops frames marked as data
// RQ2 - Transmitter ignores the filter mode
// RQ3 - Sizes five to eight: first stop bit types
// RQ4 - Nine-bit size: ninth bit types frame
// RQ5 - Type one is address, zero data
// RQ6 - Address frames buffered, receive-complete set
// RQ7 - Master sends nine-bit, ninth bit marks address
// RQ8 - Slave software toggles filter after addressing
// RQ9 - Short sizes need two stop bits
// RQ10 - No read-modify-write on filter bit
// RQ11 - Data address: write transmits, read receives
// RQ12 - Short sizes: upper bits ignored, read zero
// RQ13 - Write while buffer full is discarded
// RQ14 - Buffered data loads shifter, shifts out
// RQ15 - Two-entry receive FIFO advances per access
// RQ16 - Software avoids read-modify-write on data
// RQ17 - Read ninth bit before low byte
// RQ18 - Write ninth bit before low byte
`timescale 1ns/100ps
module umf_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Recovered frames from the bit sampler
  input wire logic rx_frame_valid_i,
  input wire logic [8:0] rx_frame_data_i,
  input wire logic rx_stop1_i,
  // Bit timing and serial output
  input wire logic baud_tick_i,
  output logic tx_o,
  // Flags to the rest of the unit
  output logic rx_complete_o,
  output logic tx_complete_o,
  output logic tx_buffer_empty_o,
  output logic irq_o
);
  import umf_pkg::*;

  umf_fifo_if fio ();
  umf_rx_fifo u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .fio(fio)
  );

  logic rx_filter_q;
  logic tx_complete_q;
  logic overrun_q;
  logic rx_en_q;
  logic tx_en_q;
  logic tx_ninth_q;
  logic stop2_q;
  logic [2:0] size_q;
  logic [UMF_IRQ_W-1:0] irq_stat_q;
  logic [UMF_IRQ_W-1:0] irq_mask_q;
  logic [8:0] tx_buf_q;
  logic tx_buf_full_q;
  logic [8:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic stop_cnt_q;
  umf_tx_state_t tx_st_q;
  logic [7:0] rdata_q;

  ////////////////////////////////////////////////////////////////
  // Decode
  wire sel_data = reg_addr_i == UMF_OFF_DATA;
  wire sel_csa = reg_addr_i == UMF_OFF_CSA;
  wire sel_csb = reg_addr_i == UMF_OFF_CSB;
  wire sel_csc = reg_addr_i == UMF_OFF_CSC;
  wire sel_istat = reg_addr_i == UMF_OFF_IRQ_STAT;
  wire sel_imask = reg_addr_i == UMF_OFF_IRQ_MASK;
  wire wr_data = reg_wr_i && sel_data;
  wire rd_data = reg_rd_i && sel_data;
  wire wr_csa = reg_wr_i && sel_csa;
  wire wr_csb = reg_wr_i && sel_csb;
  wire wr_csc = reg_wr_i && sel_csc;

  wire size_nine = size_q == UMF_SIZE_NINE;
  wire [3:0] nbits = size_nine ? UMF_NBITS_NINE :
                     (size_q[2] ? UMF_NBITS_DFLT : UMF_NBITS_BASE + {2'b00, size_q[1:0]});
  wire [8:0] size_mask = 9'h1ff >> (4'h9 - nbits);

  ////////////////////////////////////////////////////////////////
  // Receive path
  wire frame_type = size_nine ? rx_frame_data_i[8] : rx_stop1_i; // RQ3 RQ4
  // Type zero marks data; only those are dropped
  wire frame_drop = rx_filter_q && !frame_type; // RQ1 RQ5
  wire rx_take = rx_frame_valid_i && rx_en_q && !frame_drop; // RQ6
  wire fifo_full = fio.count == 2'h2;
  assign fio.push = rx_take && !fifo_full;
  assign fio.push_data = {!rx_stop1_i, rx_frame_data_i & size_mask}; // RQ12
  // Every data-location read advances the FIFO, test-only reads too
  assign fio.pop = rd_data; // RQ15
  assign fio.flush = !rx_en_q;
  wire overrun_set = rx_take && fifo_full;
  wire drop_evt = rx_frame_valid_i && rx_en_q && frame_drop;

  ////////////////////////////////////////////////////////////////
  // Transmit path, no term here looks at the filter bit
  wire tx_load = (tx_st_q == UMF_TX_IDLE) && tx_en_q && tx_buf_full_q; // RQ14 RQ2
  wire tx_last_bit = bit_cnt_q == nbits - 4'h1;
  wire tx_done = (tx_st_q == UMF_TX_STOP) && baud_tick_i && (stop_cnt_q == stop2_q);
  // Write accepted only while the buffer is empty
  wire tx_accept = wr_data && !tx_buf_full_q; // RQ13 RQ11
  wire txc_set = tx_done && !tx_buf_full_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_buf_q <= '0;
      tx_buf_full_q <= 1'b0;
    end else if (tx_accept) begin
      tx_buf_q <= {tx_ninth_q, reg_wdata_i} & size_mask; // RQ12
      tx_buf_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_st_q <= UMF_TX_IDLE;
      shift_q <= '0;
      bit_cnt_q <= '0;
      stop_cnt_q <= 1'b0;
    end else begin
      unique case (tx_st_q)
        UMF_TX_IDLE: begin
          if (tx_load) begin
            shift_q <= tx_buf_q; // RQ14
            tx_st_q <= UMF_TX_START;
          end
        end
        UMF_TX_START: begin
          bit_cnt_q <= '0;
          stop_cnt_q <= 1'b0;
          if (baud_tick_i) begin
            tx_st_q <= UMF_TX_DATA;
          end
        end
        UMF_TX_DATA: begin
          if (baud_tick_i) begin
            shift_q <= shift_q >> 1;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (tx_last_bit) begin
              tx_st_q <= UMF_TX_STOP;
            end
          end
        end
        UMF_TX_STOP: begin
          if (baud_tick_i) begin
            stop_cnt_q <= 1'b1;
            if (stop_cnt_q == stop2_q) begin
              tx_st_q <= UMF_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign tx_o = (tx_st_q == UMF_TX_START) ? 1'b0 : ((tx_st_q == UMF_TX_DATA) ? shift_q[0] : 1'b1);

  ////////////////////////////////////////////////////////////////
  // Control and sticky flags, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_filter_q <= 1'b0;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_ninth_q <= 1'b0;
      stop2_q <= 1'b0;
      size_q <= UMF_SIZE_RST;
    end else begin
      if (wr_csa) begin
        rx_filter_q <= reg_wdata_i[UMF_A_FILT];
      end
      if (wr_csb) begin
        rx_en_q <= reg_wdata_i[UMF_B_RXEN];
        tx_en_q <= reg_wdata_i[UMF_B_TXEN];
        size_q[2] <= reg_wdata_i[UMF_B_SIZE2];
        tx_ninth_q <= reg_wdata_i[UMF_B_TX9];
      end
      if (wr_csc) begin
        stop2_q <= reg_wdata_i[UMF_C_STOP2];
        size_q[1:0] <= reg_wdata_i[UMF_C_SIZE_LO +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_complete_q <= 1'b0;
      overrun_q <= 1'b0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      tx_complete_q <= txc_set || (tx_complete_q && !(wr_csa && reg_wdata_i[UMF_A_TX_DONE]));
      overrun_q <= overrun_set || (overrun_q && !rd_data);
      irq_stat_q <= {drop_evt, txc_set, fio.push} |
                    (irq_stat_q & ~({UMF_IRQ_W{reg_wr_i && sel_istat}} & reg_wdata_i[UMF_IRQ_W-1:0]));
      if (reg_wr_i && sel_imask) begin
        irq_mask_q <= reg_wdata_i[UMF_IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read back, data one cycle after the strobe
  wire [7:0] csa_val = {fio.count != 2'h0, tx_complete_q, !tx_buf_full_q, fio.head[UMF_FE_POS],
                        overrun_q, 2'b00, rx_filter_q};
  wire [7:0] csb_val = {3'b000, rx_en_q, tx_en_q, size_q[2], fio.head[8], tx_ninth_q};
  wire [7:0] csc_val = {4'h0, stop2_q, size_q[1:0], 1'b0};
  wire [7:0] rd_mux = sel_data ? fio.head[7:0] : // RQ11
                      sel_csa ? csa_val :
                      sel_csb ? csb_val :
                      sel_csc ? csc_val :
                      sel_istat ? {5'h00, irq_stat_q} :
                      sel_imask ? {5'h00, irq_mask_q} : 8'h00;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign rx_complete_o = fio.count != 2'h0;
  assign tx_complete_o = tx_complete_q;
  assign tx_buffer_empty_o = !tx_buf_full_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_DROP_DATA: assert property ( // RQ1
    rx_frame_valid_i && rx_en_q && rx_filter_q && !frame_type |-> !fio.push)
    else $error("data frame entered buffer in filter mode");
  AST_STOP_TYPE: assert property ( // RQ3
    rx_frame_valid_i && rx_en_q && rx_filter_q && !size_nine && rx_stop1_i && !fifo_full |-> fio.push)
    else $error("stop bit address frame not buffered");
  AST_NINTH_TYPE: assert property ( // RQ4
    rx_frame_valid_i && rx_en_q && rx_filter_q && size_nine && !rx_frame_data_i[8] |-> !fio.push)
    else $error("ninth bit zero frame accepted while filtering");
  AST_ADDR_RXC: assert property ( // RQ6
    rx_frame_valid_i && rx_en_q && rx_filter_q && frame_type && fio.count == 2'h0 && !rd_data
    |=> rx_complete_o)
    else $error("address frame did not set receive complete");
  AST_WRITE_DISCARD: assert property ( // RQ13
    wr_data && tx_buf_full_q |=> tx_buf_q == $past(tx_buf_q))
    else $error("write with full buffer changed transmit buffer");
  AST_READ_POPS: assert property ( // RQ15
    rd_data && fio.count != 2'h0 && !fio.push && rx_en_q |=> fio.count == $past(fio.count) - 2'h1)
    else $error("data read did not advance receive fifo");
  AST_WRITE_NO_POP: assert property ( // RQ11
    wr_data && fio.count == 2'h1 && !fio.push && rx_en_q |=> fio.count == 2'h1)
    else $error("data write disturbed receive fifo");
  AST_TX_MASK: assert property ( // RQ12
    tx_accept && size_q == 3'h0 |=> tx_buf_q[8:5] == 4'h0)
    else $error("upper bits of short transmit word not ignored");
  AST_UPPER_BITS: assert property ( // RQ12
    fio.push && size_q == 3'h0 |-> fio.push_data[8:5] == 4'h0)
    else $error("upper bits of short character not zero");
  AST_ADDR_NINE: assert property ( // RQ5
    rx_frame_valid_i && rx_en_q && rx_filter_q && size_nine && rx_frame_data_i[8] && !fifo_full |-> fio.push)
    else $error("ninth bit one frame not buffered while filtering");
  AST_DROP_IRQ: assert property ( // RQ1
    drop_evt |=> irq_stat_q[UMF_IRQ_DROP])
    else $error("dropped data frame not flagged");
  AST_DATA_READ: assert property ( // RQ11
    rd_data |=> reg_rdata_o == $past(fio.head[7:0]))
    else $error("data read did not return receive head");

  // Transmit side
  AST_TX_START: assert property ( // RQ14
    tx_load |=> !tx_o && tx_st_q == UMF_TX_START && tx_buffer_empty_o)
    else $error("loaded data did not start a frame");
  AST_WRITE_FILLS: assert property ( // RQ11
    tx_accept |=> !tx_buffer_empty_o)
    else $error("accepted data write did not fill transmit buffer");
  AST_FULL_HOLD: assert property ( // RQ13
    tx_buf_full_q && !tx_load |=> !tx_buffer_empty_o)
    else $error("full transmit buffer emptied without a load");
  // Filter bit must never gate the shifter
  AST_TX_NO_FILTER: assert property ( // RQ2
    tx_st_q == UMF_TX_IDLE && tx_en_q && tx_buf_full_q |=> tx_st_q == UMF_TX_START)
    else $error("buffered data not loaded while idle");
  AST_TXC_SET: assert property ( // RQ14
    txc_set |=> tx_complete_o)
    else $error("finished frame did not set transmit complete");
  AST_IDLE_HIGH: assert property ( // RQ14
    tx_st_q == UMF_TX_IDLE |-> tx_o)
    else $error("serial output low while idle");
endmodule : umf_top

// ### verification/umf_master_model.sv
`timescale 1ns/100ps
module umf_master_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Frame requests from the bench
  input wire logic send_i,
  input wire logic [8:0] send_data_i,
  input wire logic send_stop1_i,
  // Recovered frame and bit timing
  output logic frame_valid_o,
  output logic [8:0] frame_data_o,
  output logic frame_stop1_o,
  output logic baud_tick_o
);
  logic [2:0] div_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign baud_tick_o = (div_q == 3'h7);
  ////////////////////////////////////////////////////////////
  // Between frames the lines flip, so stale data never looks valid
  always_ff @(posedge sys_clk_i) begin
    frame_valid_o <= send_i & ~reset_i;
    frame_data_o <= send_i ? send_data_i : (reset_i ? 9'h000 : ~frame_data_o);
    frame_stop1_o <= send_i ? send_stop1_i : (reset_i ? 1'b1 : ~frame_stop1_o);
  end
endmodule : umf_master_model

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import umf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic rx_frame_valid_i;
  logic [8:0] rx_frame_data_i;
  logic rx_stop1_i;
  logic baud_tick_i;
  logic tx_o;
  logic rx_complete_o;
  logic tx_complete_o;
  logic tx_buffer_empty_o;
  logic irq_o;
  logic send = 1'b0;
  logic [8:0] send_data = 9'h000;
  logic send_stop1 = 1'b1;
  logic rd_q = 1'b0;
  logic [7:0] exp_rd[$];
  logic [8:0] exp_tx[$];
  logic [8:0] tx_sh = 9'h000;
  logic [7:0] r1;
  logic [7:0] r2;
  int tx_cnt = 0;
  int tx_nb = 8;
  int tx_stops = 1;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h9a34;

  umf_top i_umf_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rx_frame_valid_i(rx_frame_valid_i), .rx_frame_data_i(rx_frame_data_i), .rx_stop1_i(rx_stop1_i),
    .baud_tick_i(baud_tick_i), .tx_o(tx_o), .rx_complete_o(rx_complete_o),
    .tx_complete_o(tx_complete_o), .tx_buffer_empty_o(tx_buffer_empty_o), .irq_o(irq_o));

  umf_master_model i_umf_master_model (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .send_i(send),
    .send_data_i(send_data), .send_stop1_i(send_stop1), .frame_valid_o(rx_frame_valid_i),
    .frame_data_o(rx_frame_data_i), .frame_stop1_o(rx_stop1_i), .baud_tick_o(baud_tick_i));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Expected value is queued when the strobe goes out
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_rd.push_back(e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd

  task automatic frame(input logic [8:0] d, input logic s);
    @(posedge sys_clk_i);
    send <= 1'b1;
    send_data <= d;
    send_stop1 <= s;
    @(posedge sys_clk_i);
    send <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : frame

  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////
  // Read data only stands the cycle after the strobe; serial decode samples at each tick
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
    if (rd_q) begin
      chk(reg_rdata_o, exp_rd.pop_front());
    end
    rd_q <= reg_rd_i;
    if (baud_tick_i) begin
      if (tx_cnt == 0) begin
        tx_cnt = (tx_o === 1'b0) ? 1 : 0;
      end else if (tx_cnt <= tx_nb) begin
        tx_sh = {tx_o, tx_sh[8:1]};
        tx_cnt++;
        if (tx_cnt == tx_nb + 1) begin
          chk(tx_sh >> (9 - tx_nb), exp_tx.pop_front());
        end
      end else begin
        // An early start bit here means a stop bit went missing
        chk(tx_o, 1'b1);
        tx_cnt = (tx_cnt == tx_nb + tx_stops) ? 0 : tx_cnt + 1;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(UMF_OFF_CSA, 8'h20);
    rd(3'h6, 8'h00);
    wr(UMF_OFF_CSB, 8'h14);
    wr(UMF_OFF_CSC, 8'h06);
    wr(UMF_OFF_CSA, 8'h01);
    frame(9'h0aa, 1'b1);
    chk(rx_complete_o, 1'b0);
    frame(9'h155, 1'b0);
    chk(rx_complete_o, 1'b1);
    rd(UMF_OFF_CSB, 8'h16);
    rd(UMF_OFF_CSA, 8'hb1);
    rd(UMF_OFF_DATA, 8'h55);
    wr(UMF_OFF_CSA, 8'h00);
    r1 = 8'($random(seed));
    r2 = 8'($random(seed));
    frame({1'b0, r1}, 1'b1);
    frame({1'b0, r2}, 1'b1);
    frame(9'h0ff, 1'b1);
    rd(UMF_OFF_CSA, 8'ha8);
    rd(UMF_OFF_DATA, r1);
    rd(UMF_OFF_DATA, r2);
    repeat (2) @(posedge sys_clk_i);
    chk(rx_complete_o, 1'b0);
    wr(UMF_OFF_CSB, 8'h10);
    wr(UMF_OFF_CSC, 8'h00);
    wr(UMF_OFF_CSA, 8'h01);
    frame(9'h1ff, 1'b0);
    frame(9'h1ff, 1'b1);
    rd(UMF_OFF_DATA, 8'h1f);
    // Filter left on while sending
    wr(UMF_OFF_CSB, 8'h18);
    wr(UMF_OFF_CSC, 8'h06);
    r1 = 8'($random(seed));
    exp_tx.push_back(r1);
    exp_tx.push_back(8'h3c);
    wr(UMF_OFF_DATA, r1);
    repeat (3) @(posedge sys_clk_i);
    chk(tx_buffer_empty_o, 1'b1);
    wr(UMF_OFF_DATA, 8'h3c);
    wr(UMF_OFF_DATA, 8'hc3);
    chk(tx_buffer_empty_o, 1'b0);
    for (int i = 0; i < 400 && tx_complete_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
    end
    chk(tx_complete_o, 1'b1);
    chk(irq_o, 1'b0);
    wr(UMF_OFF_IRQ_MASK, 8'h02);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 1'b1);
    wr(UMF_OFF_IRQ_STAT, 8'h02);
    wr(UMF_OFF_CSA, 8'h41);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 1'b0);
    chk(tx_complete_o, 1'b0);
    // Nine-bit words with two stop bits, back to back
    tx_nb = 9;
    tx_stops = 2;
    wr(UMF_OFF_CSC, 8'h0e);
    wr(UMF_OFF_CSB, 8'h1d);
    r2 = 8'($random(seed));
    exp_tx.push_back({1'b1, r2});
    exp_tx.push_back(9'h05a);
    wr(UMF_OFF_DATA, r2);
    wr(UMF_OFF_CSB, 8'h1c);
    wr(UMF_OFF_DATA, 8'h5a);
    for (int i = 0; i < 400 && tx_complete_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
    end
    chk(tx_complete_o, 1'b1);
    chk(9'(exp_tx.size()), 9'h000);
    end_sim();
  end
endmodule : testbench
